// ==== logic/flash_host_ctrl.sv ====
// Host controller that drives flash command sequences and reads over the flash pins
// Notes on behaviour
// RL1 - Stray write sequence returns flash to read
// RL2 - Reset is F0, or unlock pair then F0
// RL3 - Reset during erase needs about 10 us
// RL4 - Auto select: unlock pair then 90 at 555
// RL5 - Id read A1A0=00 gives manufacturer code
// RL6 - Id read A1A0=01 gives device code
// RL7 - Only low eleven address bits are compared
// RL8 - Program: unlock, A0 at 555, data at target
// RL9 - Flash ignores commands while program runs
// RL10 - Reads during program return status byte
// RL11 - Failure holds status until reset issued
// RL12 - Programming zero back to one fails
// RL13 - Bypass: unlock pair then 20 at 555
// RL14 - Bypass program: A0 then data at target
// RL15 - Reset after bypass failure stays bypass
// RL16 - Bypass exit: 90 then 00 anywhere
// RL17 - Erase: six writes ending 10 at 555
// RL18 - Reads during erase return status
// RL19 - Completed erase leaves all bits one
// RL20 - Address latched at fall, data at rise
// RL21 - Polling bit inverts programmed bit value
// RL22 - Alternating bit flips every status read
// RL23 - Failure bit set when operation fails
// RL24 - Busy duration is a flash model parameter
`timescale 1ns/1ps
module flash_host_ctrl
  import flash_host_pkg::*;
#(
  parameter logic [10:0] ABORT_WAIT = ABORT_CYC   // Wait after erase abort
)(
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        req_valid,       // User request strobe
  output logic             req_ready,       // Idle and able to take one
  input  wire req_t        req,             // Operation, address, data
  output logic             done,            // One-cycle completion pulse
  output logic [7:0]       rd_data_reg,     // Last read byte
  output logic             op_fail_reg,     // Failure bit seen while polling
  output pins_t            pins_reg,        // Flash control and address pins
  output logic [7:0]       data_out_reg,    // Data lines driven value
  output logic             data_oe_reg,     // Data lines output enable
  input  wire logic [7:0]  data_in          // Data lines sampled value
);
  // ==========================================================================
  // State machine
  typedef enum logic [6:0] {
    S_IDLE   = 7'b000_0001,
    S_SETUP  = 7'b000_0010,
    S_STROBE = 7'b000_0100,
    S_HOLD   = 7'b000_1000,
    S_READ   = 7'b001_0000,
    S_ABORT  = 7'b010_0000,
    S_DONE   = 7'b100_0000
  } state_t;

  state_t      state_reg;      // Current state
  state_t      state_next;     // Next state
  req_t        cur_reg;        // Latched request
  logic [2:0]  step_reg;       // Write step index
  logic [3:0]  cnt_reg;        // Phase timer
  logic [10:0] abort_reg;      // Abort wait timer
  logic        erasing_reg;    // Erase was started and not finished
  bus_word_t   word;           // Current write step from table
  logic        last_step;      // Final write of the sequence
  logic        phase_end;      // Phase timer expired
  req_t        rom_req;        // Request the table looks up next
  logic [2:0]  rom_step;       // Step the table looks up next

  // Number of writes of each operation
  function automatic logic [2:0] seq_len(input op_t o);
    case (o)
      OP_RESET:    seq_len = 3'h1;
      OP_RESET3:   seq_len = 3'h3;
      OP_AUTOSEL:  seq_len = 3'h3;
      OP_PROGRAM:  seq_len = 3'h4;        // [RL8]
      OP_BYPASS:   seq_len = 3'h3;        // [RL13]
      OP_BYP_PRG:  seq_len = 3'h2;        // [RL14]
      OP_BYP_EXIT: seq_len = 3'h2;        // [RL16]
      OP_ERASE:    seq_len = 3'h6;        // [RL17]
      default:     seq_len = 3'h0;
    endcase
  endfunction : seq_len

  // Table of write steps; commands RL2 RL4 RL8 RL13 RL14 RL16 RL17
  flash_seq_rom u_rom (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .op        (rom_req.op),
    .step      (rom_step),
    .user_addr (rom_req.addr),
    .user_data (rom_req.data),
    .word_reg  (word)
  );

  assign last_step = (step_reg == seq_len(cur_reg.op) - 3'h1);
  assign phase_end = (cnt_reg == ONE_4);
  assign req_ready = (state_reg == S_IDLE);
  assign done      = (state_reg == S_DONE);
  // Table runs one step ahead, so its registered word is ready in setup
  assign rom_req   = req_ready ? req : cur_reg;
  assign rom_step  = (state_reg == S_HOLD && phase_end && !last_step) ? step_reg + 3'h1 :
                     req_ready ? 3'h0 : step_reg;

  // ==========================================================================
  // Next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE: begin
        if (req_valid) begin
          if (req.op == OP_READ || req.op == OP_POLL) begin
            state_next = S_READ;
          end else begin
            state_next = S_SETUP;
          end
        end
      end
      S_SETUP:  if (phase_end) state_next = S_STROBE;
      S_STROBE: if (phase_end) state_next = S_HOLD;
      S_HOLD: begin
        if (phase_end) begin
          if (!last_step) begin
            state_next = S_SETUP;
          end else if ((cur_reg.op == OP_RESET || cur_reg.op == OP_RESET3)
                       && erasing_reg) begin
            state_next = S_ABORT;           // [RL3]
          end else begin
            state_next = S_DONE;
          end
        end
      end
      S_READ:   if (phase_end) state_next = S_DONE;
      S_ABORT:  if (abort_reg == ONE_11) state_next = S_DONE;
      S_DONE:   state_next = S_IDLE;
      default:  state_next = S_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) state_reg <= S_IDLE;
    else         state_reg <= state_next;
  end

  // Request latch and step counter
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cur_reg  <= '0;
      step_reg <= 3'h0;
    end else if (state_reg == S_IDLE && req_valid) begin
      cur_reg  <= req;
      step_reg <= 3'h0;
    end else if (state_reg == S_HOLD && phase_end && !last_step) begin
      step_reg <= step_reg + 3'h1;
    end
  end

  // Phase timer, reloaded on each phase entry
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_reg <= ONE_4;
    end else if (state_next != state_reg || (state_reg == S_HOLD && phase_end)) begin
      case (state_next)
        S_SETUP:  cnt_reg <= SETUP_CYC;
        S_STROBE: cnt_reg <= STROBE_CYC;
        S_HOLD:   cnt_reg <= HOLD_CYC;
        S_READ:   cnt_reg <= READ_CYC;
        default:  cnt_reg <= ONE_4;
      endcase
    end else if (!phase_end) begin
      cnt_reg <= cnt_reg - ONE_4;
    end
  end

  // Abort wait timer
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      abort_reg <= ONE_11;
    end else if (state_next == S_ABORT && state_reg != S_ABORT) begin
      abort_reg <= ABORT_WAIT;            // [RL3]
    end else if (state_reg == S_ABORT && abort_reg != ONE_11) begin
      abort_reg <= abort_reg - ONE_11;
    end
  end

  // Erase tracking: set on erase launch, cleared by a good poll or reset
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      erasing_reg <= 1'b0;
    end else if (state_reg == S_DONE && cur_reg.op == OP_ERASE) begin
      erasing_reg <= 1'b1;
    end else if (state_reg == S_DONE && (cur_reg.op == OP_RESET || cur_reg.op == OP_RESET3)) begin
      erasing_reg <= 1'b0;
    end else if (state_reg == S_DONE && cur_reg.op == OP_POLL && !op_fail_reg
                 && rd_data_reg[POLLING_BIT]) begin
      erasing_reg <= 1'b0;                // [RL19]
    end
  end

  // ==========================================================================
  // Pins: address set in setup, strobes low in strobe phase
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pins_reg     <= '{chip_sel_n: 1'b1, out_gate_n: 1'b1, write_n: 1'b1,
                        address_lines: 16'h0000};
      data_out_reg <= 8'h00;
      data_oe_reg  <= 1'b0;
    end else begin
      case (state_next)
        S_SETUP: begin
          pins_reg.address_lines <= word.addr;     // [RL7]
          data_out_reg           <= word.data;
          data_oe_reg            <= 1'b1;
          pins_reg.chip_sel_n    <= 1'b1;
          pins_reg.write_n       <= 1'b1;
          pins_reg.out_gate_n    <= 1'b1;
        end
        S_STROBE: begin
          pins_reg.chip_sel_n <= 1'b0;     // [RL20]
          pins_reg.write_n    <= 1'b0;
        end
        S_HOLD: begin
          pins_reg.chip_sel_n <= 1'b1;     // [RL20]
          pins_reg.write_n    <= 1'b1;
        end
        S_READ: begin
          if (state_reg == S_IDLE) begin
            pins_reg.address_lines <= req.addr;
          end
          data_oe_reg         <= 1'b0;
          pins_reg.chip_sel_n <= 1'b0;
          pins_reg.out_gate_n <= 1'b0;
        end
        default: begin
          data_oe_reg         <= 1'b0;
          pins_reg.chip_sel_n <= 1'b1;
          pins_reg.out_gate_n <= 1'b1;
          pins_reg.write_n    <= 1'b1;
        end
      endcase
    end
  end

  // Read capture and failure flag; failure kept until a reset command
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data_reg <= 8'h00;
      op_fail_reg <= 1'b0;
    end else if (state_reg == S_READ && phase_end) begin
      rd_data_reg <= data_in;                                  // [RL10] [RL18]
      if (cur_reg.op == OP_POLL && data_in[FAILURE_BIT]) begin
        op_fail_reg <= 1'b1;                                   // [RL23] [RL11]
      end
    end else if (state_reg == S_DONE
                 && (cur_reg.op == OP_RESET || cur_reg.op == OP_RESET3)) begin
      op_fail_reg <= 1'b0;                                     // [RL11] [RL15]
    end
  end

  // ==========================================================================
  // Assertions
  property p_write_low_time;  // [RL20]
    @(posedge clk_sys) disable iff (sys_rst)
      $fell(pins_reg.write_n) |-> !pins_reg.write_n [*5];
  endproperty
  a_write_low_time: assert property (p_write_low_time) else $error("write strobe too short");

  property p_no_read_during_write;  // [RL20]
    @(posedge clk_sys) disable iff (sys_rst)
      !pins_reg.write_n |-> pins_reg.out_gate_n && data_oe_reg;
  endproperty
  a_no_read_during_write: assert property (p_no_read_during_write)
    else $error("output gate low during write");

  property p_reset_single;  // [RL2]
    @(posedge clk_sys) disable iff (sys_rst)
      $fell(pins_reg.write_n) && cur_reg.op == OP_RESET |-> data_out_reg == CMD_RESET;
  endproperty
  a_reset_single: assert property (p_reset_single) else $error("reset data not F0");

  property p_unlock_first;  // [RL4]
    @(posedge clk_sys) disable iff (sys_rst)
      $fell(pins_reg.write_n) && step_reg == 3'h0 && cur_reg.op == OP_AUTOSEL
      |-> data_out_reg == UNLOCK_DATA_1 && pins_reg.address_lines == UNLOCK_ADDR_1;
  endproperty
  a_unlock_first: assert property (p_unlock_first) else $error("first unlock wrong");

  property p_program_third;  // [RL8]
    @(posedge clk_sys) disable iff (sys_rst)
      $fell(pins_reg.write_n) && step_reg == 3'h2 && cur_reg.op == OP_PROGRAM
      |-> data_out_reg == CMD_PROGRAM;
  endproperty
  a_program_third: assert property (p_program_third) else $error("program code wrong");

  property p_erase_last;  // [RL17]
    @(posedge clk_sys) disable iff (sys_rst)
      $fell(pins_reg.write_n) && step_reg == 3'h5
      |-> data_out_reg == CMD_ERASE && pins_reg.address_lines == UNLOCK_ADDR_1;
  endproperty
  a_erase_last: assert property (p_erase_last) else $error("erase final write wrong");

  property p_abort_wait;  // [RL3]
    @(posedge clk_sys) disable iff (sys_rst)
      $rose(state_reg == S_ABORT) |-> !done [*8];
  endproperty
  a_abort_wait: assert property (p_abort_wait) else $error("abort wait too short");

  property p_fail_sticky;  // [RL11]
    @(posedge clk_sys) disable iff (sys_rst)
      op_fail_reg && !(state_reg == S_DONE
                       && (cur_reg.op == OP_RESET || cur_reg.op == OP_RESET3))
      |=> op_fail_reg;
  endproperty
  a_fail_sticky: assert property (p_fail_sticky) else $error("failure flag lost");
endmodule : flash_host_ctrl

// ==== logic/flash_host_pkg.sv ====
// Package with flash command constants, timing and carrier types for the host controller
package flash_host_pkg;
  // ==========================================================================
  // Widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // ==========================================================================
  // Command addresses and data
  localparam logic [15:0] UNLOCK_ADDR_1 = 16'h0555;
  localparam logic [15:0] UNLOCK_ADDR_2 = 16'h02AA;
  localparam logic [7:0]  UNLOCK_DATA_1 = 8'hAA;
  localparam logic [7:0]  UNLOCK_DATA_2 = 8'h55;
  localparam logic [7:0]  CMD_RESET     = 8'hF0;
  localparam logic [7:0]  CMD_AUTOSEL   = 8'h90;
  localparam logic [7:0]  CMD_PROGRAM   = 8'hA0;
  localparam logic [7:0]  CMD_BYPASS    = 8'h20;
  localparam logic [7:0]  CMD_ERASE_PRE = 8'h80;
  localparam logic [7:0]  CMD_ERASE     = 8'h10;
  localparam logic [7:0]  CMD_BYP_EXIT1 = 8'h90;
  localparam logic [7:0]  CMD_BYP_EXIT2 = 8'h00;
  localparam logic [15:0] ID_MFR_ADDR   = 16'h0000;
  localparam logic [15:0] ID_DEV_ADDR   = 16'h0001;

  // ==========================================================================
  // Status bit positions
  localparam int POLLING_BIT     = 7;
  localparam int ALTERNATING_BIT = 6;
  localparam int FAILURE_BIT     = 5;

  // ==========================================================================
  // Bus timing, in ns and derived cycles at 100 MHz
  localparam int CLK_NS       = 10;
  localparam int SETUP_NS     = 20;
  localparam int STROBE_NS    = 50;
  localparam int HOLD_NS      = 20;
  localparam int READ_NS      = 80;
  localparam int ABORT_NS     = 10000;
  localparam logic [3:0] SETUP_CYC  = 4'((SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] STROBE_CYC = 4'((STROBE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] HOLD_CYC   = 4'((HOLD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] READ_CYC   = 4'((READ_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [10:0] ABORT_CYC = 11'((ABORT_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] ONE_4      = 4'h1;
  localparam logic [10:0] ONE_11    = 11'h001;

  // ==========================================================================
  // Operation codes of the user command port
  typedef enum logic [3:0] {
    OP_READ    = 4'h0,
    OP_RESET   = 4'h1,
    OP_RESET3  = 4'h2,
    OP_AUTOSEL = 4'h3,
    OP_PROGRAM = 4'h4,
    OP_BYPASS  = 4'h5,
    OP_BYP_PRG = 4'h6,
    OP_BYP_EXIT= 4'h7,
    OP_ERASE   = 4'h8,
    OP_POLL    = 4'h9
  } op_t;

  // One bus write step
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
  } bus_word_t;

  // User request
  typedef struct packed {
    op_t         op;
    logic [15:0] addr;
    logic [7:0]  data;
  } req_t;

  // Pins to the flash
  typedef struct packed {
    logic        chip_sel_n;
    logic        out_gate_n;
    logic        write_n;
    logic [15:0] address_lines;
  } pins_t;
endpackage : flash_host_pkg

// ==== logic/flash_seq_rom.sv ====
// Sequence table: bus write steps of each command, read from a register
`timescale 1ns/1ps
module flash_seq_rom
  import flash_host_pkg::*;
(
  input  wire logic      clk_sys,
  input  wire logic      sys_rst,
  input  wire op_t       op,
  input  wire logic [2:0] step,
  input  wire logic [15:0] user_addr,
  input  wire logic [7:0]  user_data,
  output bus_word_t      word_reg
);
  // ==========================================================================
  // Table lookup
  function automatic bus_word_t lookup(input op_t o, input logic [2:0] s,
                                       input logic [15:0] a, input logic [7:0] d);
    bus_word_t u1;
    bus_word_t u2;
    bus_word_t w;
    u1 = '{addr: UNLOCK_ADDR_1, data: UNLOCK_DATA_1};
    u2 = '{addr: UNLOCK_ADDR_2, data: UNLOCK_DATA_2};
    w  = '{addr: a, data: d};
    case (s)
      3'h0: lookup = (o == OP_RESET) ? bus_word_t'{addr: a, data: CMD_RESET} :
                     (o == OP_BYP_PRG) ? bus_word_t'{addr: a, data: CMD_PROGRAM} :
                     (o == OP_BYP_EXIT) ? bus_word_t'{addr: a, data: CMD_BYP_EXIT1} : u1;
      3'h1: lookup = (o == OP_BYP_PRG) ? w :
                     (o == OP_BYP_EXIT) ? bus_word_t'{addr: a, data: CMD_BYP_EXIT2} : u2;
      3'h2: begin
        case (o)
          OP_RESET3:  lookup = '{addr: a, data: CMD_RESET};
          OP_AUTOSEL: lookup = '{addr: UNLOCK_ADDR_1, data: CMD_AUTOSEL};
          OP_PROGRAM: lookup = '{addr: UNLOCK_ADDR_1, data: CMD_PROGRAM};
          OP_BYPASS:  lookup = '{addr: UNLOCK_ADDR_1, data: CMD_BYPASS};
          default:    lookup = '{addr: UNLOCK_ADDR_1, data: CMD_ERASE_PRE};
        endcase
      end
      3'h3: lookup = (o == OP_PROGRAM) ? w : u1;
      3'h4: lookup = u2;
      default: lookup = '{addr: UNLOCK_ADDR_1, data: CMD_ERASE};
    endcase
  endfunction : lookup

  // Registered read data
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      word_reg <= '0;
    end else begin
      word_reg <= lookup(op, step, user_addr, user_data);
    end
  end
endmodule : flash_seq_rom

// ==== verification/flash_dev_model.sv ====
// Behavioural model of the byte-wide flash device on the far side of the host pins
`timescale 1ns/1ps
module flash_dev_model
  import flash_host_pkg::*;
#(
  parameter int         BUSY_NS  = 2000,   // Embedded operation length
  parameter int         ABORT_NS = 100,    // Erase abort interval
  parameter logic [7:0] MFR_CODE = 8'h5A,  // Arbitrary value
  parameter logic [7:0] DEV_CODE = 8'hC3   // Arbitrary value
)(
  input  wire pins_t      pins,
  input  wire logic [7:0] dq_in,
  output logic [7:0]      dq_out
);
  // ==========================================================================
  // State
  logic [7:0]  mem [0:65535];  // Array contents
  logic [15:0] lat_addr;       // Address of the current write
  logic [15:0] tgt_addr;       // Program target
  logic [7:0]  tgt_data;       // Program value
  logic [7:0]  last_q;         // Last byte driven
  logic [7:0]  view;           // Byte shown when read
  int          step;           // Sequence progress
  int          op_id;          // Operation token
  bit          id_mode, byp, busy, failed, erasing, aborting, tog, perr, bad;
  wire         wr = !pins.chip_sel_n && !pins.write_n;
  wire         rd = !pins.chip_sel_n && !pins.out_gate_n && pins.write_n;

  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = 8'hFF;
    last_q = 8'h00;
  end

  // Command word matches on low address bits only
  function automatic bit hit(input logic [15:0] ca, input logic [7:0] cd);
    return lat_addr[10:0] == ca[10:0] && dq_in == cd;
  endfunction : hit

  // Start the embedded controller
  task automatic launch(input bit erase, input logic [7:0] d);
    tgt_addr = lat_addr;
    tgt_data = d;
    erasing = erase;
    perr = !erase && |(d & ~mem[lat_addr]);
    id_mode = 1'b0;
    busy = 1'b1;
    op_id++;
  endtask : launch

  // ==========================================================================
  // Bus write decoding
  always @(posedge wr) lat_addr = pins.address_lines;
  always @(negedge wr) begin : cmd_write
    if (busy && erasing && dq_in == CMD_RESET) begin
      busy = 1'b0;
      erasing = 1'b0;
      aborting = 1'b1;
    end else if (!busy && !aborting) begin
      bad = 1'b0;
      if (dq_in == CMD_RESET && step != 3 && step != 7) begin
        failed = 1'b0;
        id_mode = 1'b0;
        step = 0;
      end else if (!failed) begin
        case (step)
          0: if (byp) step = (dq_in == CMD_PROGRAM) ? 7 : (dq_in == CMD_BYP_EXIT1) ? 8 : 0;
             else step = hit(UNLOCK_ADDR_1, UNLOCK_DATA_1) ? 1 : 0;
          1: step = hit(UNLOCK_ADDR_2, UNLOCK_DATA_2) ? 2 : 0;
          2: begin
            step = 0;
            if (hit(UNLOCK_ADDR_1, CMD_AUTOSEL)) id_mode = 1'b1;
            else if (hit(UNLOCK_ADDR_1, CMD_BYPASS)) byp = 1'b1;
            else if (hit(UNLOCK_ADDR_1, CMD_PROGRAM)) step = 3;
            else if (hit(UNLOCK_ADDR_1, CMD_ERASE_PRE)) step = 4;
            else bad = 1'b1;
          end
          3, 7: begin
            launch(1'b0, dq_in);
            step = 0;
          end
          4: step = hit(UNLOCK_ADDR_1, UNLOCK_DATA_1) ? 5 : 0;
          5: step = hit(UNLOCK_ADDR_2, UNLOCK_DATA_2) ? 6 : 0;
          6: begin
            step = 0;
            if (hit(UNLOCK_ADDR_1, CMD_ERASE)) launch(1'b1, dq_in);
            else bad = 1'b1;
          end
          default: begin
            step = 0;
            if (dq_in == CMD_BYP_EXIT2) byp = 1'b0;
          end
        endcase
        if (step == 0 && !byp && (bad || !id_mode)) id_mode = id_mode && !bad;
      end
    end
  end

  // ==========================================================================
  // Embedded controller and abort timing
  always begin : embedded_op
    int id;
    wait (busy);
    id = op_id;
    #(BUSY_NS);
    if (busy && id == op_id) begin
      if (erasing) for (int i = 0; i < 65536; i++) mem[i] = 8'hFF;
      else if (!perr) mem[tgt_addr] = tgt_data;
      failed = perr;
      busy = 1'b0;
    end
  end
  always @(posedge aborting) begin : abort_wait
    #(ABORT_NS);
    aborting = 1'b0;
  end

  // ==========================================================================
  // Read data; released lines show the inverse of the last byte
  always @* begin : read_view
    if (busy || failed) view = {~erasing & ~tgt_data[7], tog, failed, 5'h00};
    else if (id_mode) view = (pins.address_lines[1:0] == 2'h0) ? MFR_CODE :
                             (pins.address_lines[1:0] == 2'h1) ? DEV_CODE : 8'h00;
    else view = mem[pins.address_lines];
  end
  always @(negedge rd) begin : read_end
    last_q = view;
    if (busy || failed) tog = ~tog;
  end
  assign dq_out = (rd && !aborting) ? view : ~last_q;
endmodule : flash_dev_model

// ==== verification/flash_host_ctrl_tb.sv ====
// Testbench of the flash host controller against the behavioural flash device
`timescale 1ns/1ps
module flash_host_ctrl_tb
  import flash_host_pkg::*;
;
  // ==========================================================================
  // Bench signals
  logic        clk_sys;
  logic        sys_rst;
  logic        req_valid;
  logic        req_ready;
  req_t        req;
  logic        done;
  logic [7:0]  rd_data_reg;
  logic        op_fail_reg;
  pins_t       pins_reg;
  logic [7:0]  data_out_reg;
  logic        data_oe_reg;
  logic [7:0]  data_in;
  logic [7:0]  dev_q;
  int          fails;
  int          num_checks;
  int          cyc;
  localparam logic [7:0] MFR = 8'h5A;  // Arbitrary value
  localparam logic [7:0] DEV = 8'hC3;  // Arbitrary value

  // Data wire: host drive wins, else the device view
  assign data_in = data_oe_reg ? data_out_reg : dev_q;

  flash_host_ctrl #(.ABORT_WAIT(11'h00A)) flash_host_ctrl_inst (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .req_valid(req_valid), .req_ready(req_ready),
    .req(req), .done(done), .rd_data_reg(rd_data_reg), .op_fail_reg(op_fail_reg),
    .pins_reg(pins_reg), .data_out_reg(data_out_reg), .data_oe_reg(data_oe_reg),
    .data_in(data_in));
  flash_dev_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) flash_dev_model_inst (
    .pins(pins_reg), .dq_in(data_in), .dq_out(dev_q));

  always #5 clk_sys = ~clk_sys;

  // ==========================================================================
  // Compare and run control
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask : chk8
  task automatic chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask : chk_bit
  task automatic chk_cyc(input int exp);
    num_checks++;
    if (cyc != exp) begin
      fails++;
      $display("CHECK FAILED at %0t: %0d cycles expected %0d", $time, cyc, exp);
    end
  endtask : chk_cyc
  task automatic test_done;
    if (fails == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  // One request, counted in cycles from the taking edge to done
  task automatic do_op(input op_t op, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    req = '{op: op, addr: a, data: d};
    req_valid = 1'b1;
    @(posedge clk_sys);
    #1;
    req_valid = 1'b0;
    cyc = 0;
    while (done !== 1'b1 && cyc < 5000) begin
      @(posedge clk_sys);
      #1;
      cyc++;
    end
    if (done !== 1'b1) begin
      fails++;
      $display("CHECK FAILED at %0t: no completion", $time);
      test_done();
    end
  endtask : do_op
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    do_op(OP_READ, a, 8'h00);
    chk8(rd_data_reg, exp);
    chk_cyc(8);
  endtask : rd_chk
  task automatic wait_op;
    repeat (250) @(posedge clk_sys);
  endtask : wait_op

  // ==========================================================================
  // Scenarios
  task automatic sc_ident;
    rd_chk(16'h0000, 8'hFF);
    do_op(OP_AUTOSEL, 16'h0000, 8'h00);
    chk_cyc(27);
    rd_chk(ID_MFR_ADDR, MFR);
    rd_chk(16'hF001, DEV);
    rd_chk(16'h7C00, MFR);
    do_op(OP_RESET, 16'h0000, 8'h00);
    chk_cyc(9);
    rd_chk(ID_DEV_ADDR, 8'hFF);
  endtask : sc_ident
  task automatic sc_program;
    logic t;
    do_op(OP_PROGRAM, 16'h1234, 8'h5A);
    chk_cyc(36);
    do_op(OP_POLL, 16'h1234, 8'h00);
    chk_bit(rd_data_reg[POLLING_BIT], 1'b1);
    chk_bit(rd_data_reg[FAILURE_BIT], 1'b0);
    t = rd_data_reg[ALTERNATING_BIT];
    do_op(OP_PROGRAM, 16'h2000, 8'h00);
    do_op(OP_POLL, 16'h2000, 8'h00);
    chk_bit(rd_data_reg[ALTERNATING_BIT], ~t);
    wait_op();
    rd_chk(16'h1234, 8'h5A);
    rd_chk(16'h2000, 8'hFF);
  endtask : sc_program
  task automatic sc_fail;
    do_op(OP_PROGRAM, 16'h1234, 8'hA5);
    wait_op();
    do_op(OP_POLL, 16'h1234, 8'h00);
    chk_bit(rd_data_reg[FAILURE_BIT], 1'b1);
    chk_bit(op_fail_reg, 1'b1);
    do_op(OP_READ, 16'h0040, 8'h00);
    chk_bit(rd_data_reg[FAILURE_BIT], 1'b1);
    do_op(OP_RESET3, 16'h0000, 8'h00);
    chk_cyc(27);
    // Failure flag clears on the cycle after done
    @(posedge clk_sys);
    #1;
    chk_bit(op_fail_reg, 1'b0);
    rd_chk(16'h1234, 8'h5A);
  endtask : sc_fail
  task automatic sc_bypass;
    do_op(OP_BYPASS, 16'h0000, 8'h00);
    chk_cyc(27);
    do_op(OP_BYP_PRG, 16'h0100, 8'h3C);
    chk_cyc(18);
    wait_op();
    rd_chk(16'h0100, 8'h3C);
    do_op(OP_BYP_PRG, 16'h0100, 8'hC3);
    wait_op();
    do_op(OP_POLL, 16'h0100, 8'h00);
    chk_bit(rd_data_reg[FAILURE_BIT], 1'b1);
    do_op(OP_RESET, 16'h0000, 8'h00);
    do_op(OP_BYP_PRG, 16'h0200, 8'h11);
    wait_op();
    rd_chk(16'h0200, 8'h11);
    do_op(OP_BYP_EXIT, 16'h0000, 8'h00);
    chk_cyc(18);
    do_op(OP_BYP_PRG, 16'h0300, 8'h22);
    wait_op();
    rd_chk(16'h0300, 8'hFF);
  endtask : sc_bypass
  task automatic sc_erase;
    do_op(OP_ERASE, 16'h0000, 8'h00);
    chk_cyc(54);
    do_op(OP_POLL, 16'h0000, 8'h00);
    chk_bit(rd_data_reg[POLLING_BIT], 1'b0);
    wait_op();
    do_op(OP_POLL, 16'h1234, 8'h00);
    chk8(rd_data_reg, 8'hFF);
    rd_chk(16'h0200, 8'hFF);
    do_op(OP_ERASE, 16'h0000, 8'h00);
    do_op(OP_RESET, 16'h0000, 8'h00);
    chk_cyc(19);
  endtask : sc_erase

  initial begin : main_seq
    clk_sys = 1'b0;
    sys_rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    fails = 0;
    num_checks = 0;
    repeat (10) @(posedge clk_sys);
    #1;
    sys_rst = 1'b0;
    sc_ident();
    sc_program();
    sc_fail();
    sc_bypass();
    sc_erase();
    test_done();
  end
endmodule : flash_host_ctrl_tb
